//--- slr_lead_router.sv
// Line-side lead routing, data sampling and error shaping of the channel
`timescale 1ns/1ps
`include "slr_consts.svh"
module slr_lead_router (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire logic                     ce,
    input  wire logic [`SLR_ADDR_W-1:0]   addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [31:0]              rdata,
    output logic      [2:0]               chan_timing,
    output logic      [27:0]              chan_rate,
    input  wire logic                     chan_clk,
    input  wire logic                     err_trig,
    input  wire logic                     east_rts_i,
    input  wire logic                     east_dtr_i,
    input  wire logic                     east_sd_i,
    output logic                          east_cts_o,
    output logic                          east_dsr_o,
    output logic                          east_dcd_o,
    output logic                          east_rd_o,
    input  wire logic [`SLR_WEST_W-1:0]   west_i,
    output logic      [`SLR_WEST_W-1:0]   west_o,
    output logic      [`SLR_WEST_W-1:0]   west_oe_n
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [27:0] mul10(input logic [23:0] r);
        logic [27:0] w;
        w = {4'h0, r};
        return (w << 3) + (w << 1);
    endfunction

    function automatic logic [15:0] bin2gray(input logic [15:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [15:0] gray2bin(input logic [15:0] g);
        logic [15:0] b;
        b = g;
        for (int i = 14; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Register port, system clock
    // ------------------------------------------------------------------
    logic        west_dce_ff;
    logic        async_ff;
    logic [2:0]  tsel_ff;
    logic [7:0]  elen_ff;
    logic [15:0] delay_ff;
    logic [23:0] rate_ff;
    logic        cfg_tog_ff;
    logic [31:0] rdata_ff;
    logic [2:0]  chan_timing_ff;
    logic [27:0] chan_rate_ff;
    logic        ack_s1_ff;
    logic        ack_s2_ff;
    logic [15:0] cnt_s1_ff;
    logic [15:0] cnt_s2_ff;
    logic [7:0]  pin_s1_ff;
    logic [7:0]  pin_s2_ff;

    wire         wr_ctrl;
    wire         wr_delay;
    wire         wr_rate;
    wire         pending;
    wire  [31:0] ctrl_rd;
    wire  [31:0] status_rd;
    wire  [31:0] rd_mux;
    wire  [2:0]  nxt_chan_timing;
    wire  [27:0] nxt_chan_rate;

    assign wr_ctrl  = wr && (addr == `SLR_OFF_CTRL);
    assign wr_delay = wr && (addr == `SLR_OFF_DELAY);
    assign wr_rate  = wr && (addr == `SLR_OFF_RATE);
    assign pending  = cfg_tog_ff ^ ack_s2_ff;

    assign nxt_chan_timing = async_ff ? `SLR_TSEL_SAMPLING : tsel_ff;
    assign nxt_chan_rate   = async_ff ? mul10(rate_ff)
                                      : {4'h0, rate_ff};

    assign ctrl_rd = {16'h0000, elen_ff, 1'b0, tsel_ff, 2'b00,
                      async_ff, west_dce_ff};
    assign status_rd = {7'h00, pin_s2_ff[7], 1'b0, pin_s2_ff[6:0],
                        9'h000, nxt_chan_timing, 2'b00, async_ff, pending};
    assign rd_mux = (addr == `SLR_OFF_CTRL)   ? ctrl_rd :
                    (addr == `SLR_OFF_DELAY)  ? {16'h0000, delay_ff} :
                    (addr == `SLR_OFF_RATE)   ? {8'h00, rate_ff} :
                    (addr == `SLR_OFF_STATUS) ? status_rd :
                    (addr == `SLR_OFF_ERRCNT) ? {16'h0000,
                                                 gray2bin(cnt_s2_ff)} :
                    32'h0000_0000;

    always_ff @(posedge clock) begin
        if (srst) begin
            west_dce_ff <= `SLR_RST_WEST_DCE;
            async_ff    <= `SLR_RST_ASYNC;
            tsel_ff     <= `SLR_RST_TSEL;
            elen_ff     <= `SLR_RST_ELEN;
            delay_ff    <= `SLR_RST_DELAY;
            rate_ff     <= `SLR_RST_RATE;
            cfg_tog_ff  <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                west_dce_ff <= wdata[`SLR_CTRL_WEST_DCE];
                async_ff    <= wdata[`SLR_CTRL_ASYNC];
                tsel_ff     <= wdata[`SLR_CTRL_TSEL_LSB +: 3];
                elen_ff     <= wdata[`SLR_CTRL_ELEN_LSB +: 8];
            end
            if (wr_delay) begin
                delay_ff <= wdata[15:0];
            end
            if (wr_rate) begin
                rate_ff <= wdata[23:0];
            end
            // Channel side picks up the whole set once this toggle has crossed
            if (wr_ctrl || wr_delay) begin
                cfg_tog_ff <= ~cfg_tog_ff;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_ff       <= 32'h0000_0000;
            chan_timing_ff <= `SLR_RST_TSEL;
            chan_rate_ff   <= 28'h000_0000;
        end else if (ce) begin
            rdata_ff       <= rd ? rd_mux : 32'h0000_0000;
            chan_timing_ff <= nxt_chan_timing;
            chan_rate_ff   <= nxt_chan_rate;
        end
    end

    // ------------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------------
    logic       ack_tog_ff;
    logic [15:0] cnt_gray_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            cnt_s1_ff <= 16'h0000;
            cnt_s2_ff <= 16'h0000;
            pin_s1_ff <= 8'h00;
            pin_s2_ff <= 8'h00;
        end else begin
            ack_s1_ff <= ack_tog_ff;
            ack_s2_ff <= ack_s1_ff;
            cnt_s1_ff <= cnt_gray_ff;
            cnt_s2_ff <= cnt_s1_ff;
            pin_s1_ff <= {east_rts_i, west_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign rdata       = rdata_ff;
    assign chan_timing = chan_timing_ff;
    assign chan_rate   = chan_rate_ff;

    // ------------------------------------------------------------------
    // Channel clock: reset, enable and pin synchronisers
    // ------------------------------------------------------------------
    logic                   lrst_s1_ff;
    logic                   lrst_s2_ff;
    logic                   lce_s1_ff;
    logic                   lce_s2_ff;
    logic                   tog_s1_ff;
    logic                   tog_s2_ff;
    logic [9:0]             lpin_s1_ff;
    logic [9:0]             lpin_s2_ff;

    always_ff @(posedge chan_clk) begin
        lrst_s1_ff <= srst;
        lrst_s2_ff <= lrst_s1_ff;
        lce_s1_ff  <= ce;
        lce_s2_ff  <= lce_s1_ff;
        tog_s1_ff  <= cfg_tog_ff;
        tog_s2_ff  <= tog_s1_ff;
        lpin_s1_ff <= {east_rts_i, east_dtr_i, east_sd_i, west_i};
        lpin_s2_ff <= lpin_s1_ff;
    end

    wire                    e_rts;
    wire                    e_dtr;
    wire                    e_sd;
    wire [`SLR_WEST_W-1:0]  w_in;

    assign e_rts = lpin_s2_ff[9];
    assign e_dtr = lpin_s2_ff[8];
    assign e_sd  = lpin_s2_ff[7];
    assign w_in  = lpin_s2_ff[6:0];

    // ------------------------------------------------------------------
    // Channel clock: configuration shadow
    // ------------------------------------------------------------------
    // Settings are held steady in the system domain while the toggle
    // crosses; back-to-back writes within a few channel cycles may
    // let the shadow take a mix, so software waits for pending to drop.
    logic       sh_dce_ff;
    logic       sh_async_ff;
    logic       sh_dzero_ff;
    logic [7:0] sh_elen_ff;
    wire        cfg_new;

    assign cfg_new = tog_s2_ff ^ ack_tog_ff;

    always_ff @(posedge chan_clk) begin
        if (lrst_s2_ff) begin
            ack_tog_ff  <= 1'b0;
            sh_dce_ff   <= `SLR_RST_WEST_DCE;
            sh_async_ff <= `SLR_RST_ASYNC;
            sh_dzero_ff <= 1'b1;
            sh_elen_ff  <= `SLR_RST_ELEN;
        end else if (lce_s2_ff && cfg_new) begin
            ack_tog_ff  <= tog_s2_ff;
            sh_dce_ff   <= west_dce_ff;
            sh_async_ff <= async_ff;
            sh_dzero_ff <= (delay_ff == 16'h0000);
            sh_elen_ff  <= elen_ff;
        end
    end

    // ------------------------------------------------------------------
    // Channel clock: error shaping and event count
    // ------------------------------------------------------------------
    // Trigger is looked at once per channel clock, which in async mode
    // is once per sample: events come ten times as often as per bit.
    slr_err_if eif ();

    assign eif.trig       = err_trig;
    assign eif.async_mode = sh_async_ff;
    assign eif.len        = sh_elen_ff;

    slr_err_shaper u_shaper (
        .chan_clk (chan_clk),
        .rst      (lrst_s2_ff),
        .ce       (lce_s2_ff),
        .eif      (eif)
    );

    logic [15:0] cnt_bin_ff;
    wire  [15:0] cnt_inc;

    assign cnt_inc = cnt_bin_ff + 16'h0001;

    // Gray code so the system side never sees a torn count
    always_ff @(posedge chan_clk) begin
        if (lrst_s2_ff) begin
            cnt_bin_ff  <= 16'h0000;
            cnt_gray_ff <= 16'h0000;
        end else if (lce_s2_ff && eif.evt) begin
            cnt_bin_ff  <= cnt_inc;
            cnt_gray_ff <= bin2gray(cnt_inc);
        end
    end

    // ------------------------------------------------------------------
    // Channel clock: lead routing and data paths
    // ------------------------------------------------------------------
    slr_pkg::slr_route_t route;

    assign route = !sh_dce_ff  ? slr_pkg::slr_route_dte :
                   sh_dzero_ff ? slr_pkg::slr_route_dce_direct :
                                 slr_pkg::slr_route_dce_delay;

    wire                   is_dte;
    wire                   is_direct;
    wire                   dat_west;
    wire                   dat_east;
    wire                   nxt_east_cts;
    wire                   nxt_east_dsr;
    wire                   nxt_east_dcd;
    wire                   nxt_east_rd;
    wire [`SLR_WEST_W-1:0] nxt_west_o;
    wire [`SLR_WEST_W-1:0] nxt_west_oe_n;

    assign is_dte    = (route == slr_pkg::slr_route_dte);
    assign is_direct = (route == slr_pkg::slr_route_dce_direct);

    // Sampled every channel clock: ten samples a bit in async mode
    assign dat_west = e_sd ^ eif.active;
    assign dat_east = (is_dte ? w_in[`SLR_W_SD] : w_in[`SLR_W_RD])
                      ^ eif.active;

    assign nxt_east_cts = is_direct ? w_in[`SLR_W_CTS] : e_rts;
    assign nxt_east_dsr = is_direct ? w_in[`SLR_W_DSR] : 1'b1;
    assign nxt_east_dcd = 1'b1;
    assign nxt_east_rd  = dat_east;

    // Terminal-side West drives CTS, DSR, DCD and RD; DTR is ignored
    assign nxt_west_o[`SLR_W_RTS] = is_direct ? e_rts : !is_dte;
    assign nxt_west_o[`SLR_W_CTS] = is_dte & w_in[`SLR_W_RTS];
    assign nxt_west_o[`SLR_W_DSR] = is_dte;
    assign nxt_west_o[`SLR_W_DCD] = is_dte;
    assign nxt_west_o[`SLR_W_DTR] = is_direct ? e_dtr : !is_dte;
    assign nxt_west_o[`SLR_W_SD]  = !is_dte & dat_west;
    assign nxt_west_o[`SLR_W_RD]  = is_dte & dat_west;

    assign nxt_west_oe_n[`SLR_W_RTS] = is_dte;
    assign nxt_west_oe_n[`SLR_W_CTS] = !is_dte;
    assign nxt_west_oe_n[`SLR_W_DSR] = !is_dte;
    assign nxt_west_oe_n[`SLR_W_DCD] = !is_dte;
    assign nxt_west_oe_n[`SLR_W_DTR] = is_dte;
    assign nxt_west_oe_n[`SLR_W_SD]  = is_dte;
    assign nxt_west_oe_n[`SLR_W_RD]  = !is_dte;

    logic                   east_cts_ff;
    logic                   east_dsr_ff;
    logic                   east_dcd_ff;
    logic                   east_rd_ff;
    logic [`SLR_WEST_W-1:0] west_o_ff;
    logic [`SLR_WEST_W-1:0] west_oe_n_ff;

    // Leads only move on a channel edge, so a mode switch never glitches
    always_ff @(posedge chan_clk) begin
        if (lrst_s2_ff) begin
            east_cts_ff  <= 1'b0;
            east_dsr_ff  <= 1'b0;
            east_dcd_ff  <= 1'b0;
            east_rd_ff   <= 1'b0;
            west_o_ff    <= 7'h00;
            west_oe_n_ff <= 7'h7F;
        end else if (lce_s2_ff) begin
            east_cts_ff  <= nxt_east_cts;
            east_dsr_ff  <= nxt_east_dsr;
            east_dcd_ff  <= nxt_east_dcd;
            east_rd_ff   <= nxt_east_rd;
            west_o_ff    <= nxt_west_o;
            west_oe_n_ff <= nxt_west_oe_n;
        end
    end

    assign east_cts_o = east_cts_ff;
    assign east_dsr_o = east_dsr_ff;
    assign east_dcd_o = east_dcd_ff;
    assign east_rd_o  = east_rd_ff;
    assign west_o     = west_o_ff;
    assign west_oe_n  = west_oe_n_ff;
endmodule

//--- slr_consts.svh
// Register offsets, field positions, reset values and counts of the router
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH

`define SLR_ADDR_W        8
`define SLR_OFF_CTRL      8'h00
`define SLR_OFF_DELAY     8'h04
`define SLR_OFF_RATE      8'h08
`define SLR_OFF_STATUS    8'h0C
`define SLR_OFF_ERRCNT    8'h10

`define SLR_CTRL_WEST_DCE 0
`define SLR_CTRL_ASYNC    1
`define SLR_CTRL_TSEL_LSB 4
`define SLR_CTRL_ELEN_LSB 8

`define SLR_ST_PEND       0
`define SLR_ST_ASYNC      1
`define SLR_ST_TSEL_LSB   4
`define SLR_ST_WEST_LSB   16
`define SLR_ST_ERTS       24

`define SLR_RST_WEST_DCE  1'h0
`define SLR_RST_ASYNC     1'h0
`define SLR_RST_TSEL      3'h0
`define SLR_RST_ELEN      8'h01
`define SLR_RST_DELAY     16'h0000
`define SLR_RST_RATE      24'h000000

`define SLR_TSEL_SAMPLING 3'h4
`define SLR_OVERSAMPLE    4'hA

`define SLR_W_RTS         0
`define SLR_W_CTS         1
`define SLR_W_DSR         2
`define SLR_W_DCD         3
`define SLR_W_DTR         4
`define SLR_W_SD          5
`define SLR_W_RD          6
`define SLR_WEST_W        7

`endif

//--- slr_pkg.sv
// Types shared by the lead router and its error shaper
package slr_pkg;
    typedef enum logic [1:0] {
        slr_route_dte,
        slr_route_dce_delay,
        slr_route_dce_direct
    } slr_route_t;

    typedef enum logic {
        slr_shp_idle,
        slr_shp_hold
    } slr_shp_state_t;
endpackage

//--- slr_err_if.sv
// Error event request and shaped result between router and shaper
`timescale 1ns/1ps
interface slr_err_if;
    logic       trig;
    logic       async_mode;
    logic [7:0] len;
    logic       active;
    logic       evt;

    modport ctl (output trig, output async_mode, output len,
                 input  active, input evt);
    modport shp (input  trig, input async_mode, input len,
                 output active, output evt);
endinterface

//--- slr_err_shaper.sv
// Shapes one error request into an event of bit or sample length
`timescale 1ns/1ps
`include "slr_consts.svh"
module slr_err_shaper (
    input  wire logic chan_clk,
    input  wire logic rst,
    input  wire logic ce,
    slr_err_if.shp    eif
);
    slr_pkg::slr_shp_state_t state_ff;
    slr_pkg::slr_shp_state_t nxt_state;
    logic [7:0]              cnt_ff;
    logic [7:0]              nxt_cnt;
    logic                    evt_ff;
    logic                    nxt_evt;
    wire  [7:0]              len_eff;

    // Async: one sample; sync: whole bits, zero treated as one
    assign len_eff = eif.async_mode ? 8'h01 :
                     (eif.len == 8'h00) ? 8'h01 : eif.len;
    assign eif.active = (state_ff == slr_pkg::slr_shp_hold);
    assign eif.evt    = evt_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_evt   = 1'b0;
        case (state_ff)
            slr_pkg::slr_shp_idle: begin
                if (eif.trig) begin
                    nxt_state = slr_pkg::slr_shp_hold;
                    nxt_cnt   = len_eff;
                    nxt_evt   = 1'b1;
                end
            end
            slr_pkg::slr_shp_hold: begin
                // Requests during an event merge into it
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    nxt_state = slr_pkg::slr_shp_idle;
                end
            end
            default: begin
                nxt_state = slr_pkg::slr_shp_idle;
            end
        endcase
    end

    always_ff @(posedge chan_clk) begin
        if (rst) begin
            state_ff <= slr_pkg::slr_shp_idle;
            cnt_ff   <= 8'h00;
            evt_ff   <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            evt_ff   <= nxt_evt;
        end
    end
endmodule

//--- slr_west_peer.sv
// Behavioural model of the equipment attached to the West port
`timescale 1ns/1ps
module slr_west_peer (
    input  wire logic       chan_clk,
    input  wire logic       dce,
    input  wire logic       slow,
    input  wire logic [6:0] drv,
    input  wire logic [6:0] dev_o,
    input  wire logic [6:0] dev_oe_n,
    output logic      [6:0] pin
);
    logic [6:0] drv_ff;
    logic [6:0] mask, val;

    // Slow mode answers one channel clock late
    always_ff @(posedge chan_clk) begin
        drv_ff <= drv;
    end

    assign mask = dce ? 7'h4E : 7'h31;
    assign val  = slow ? drv_ff : drv;
    // A lead nobody drives shows the inverse of the level on dev_o
    assign pin  = (~dev_oe_n & dev_o) | (dev_oe_n & mask & val)
                | (dev_oe_n & ~mask & ~dev_o);
endmodule

//--- slr_lead_router_chk.sv
// Concurrent checks on the ports of the lead router
`timescale 1ns/1ps
`include "slr_consts.svh"
module slr_lead_router_chk (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [2:0]  chan_timing,
    input wire logic [27:0] chan_rate,
    input wire logic        chan_clk,
    input wire logic        err_trig,
    input wire logic        east_rts_i,
    input wire logic        east_cts_o,
    input wire logic        east_dcd_o,
    input wire logic [6:0]  west_i,
    input wire logic [6:0]  west_o,
    input wire logic [6:0]  west_oe_n
);
    // ------
    // Shadow of the configuration
    // ------
    logic        dce_ff, async_ff, dly0_ff, settled, up, mapped, cfg_wr;
    logic [23:0] rate_ff;
    logic [27:0] rate_exp;
    logic [5:0]  quiet_ff;
    logic [2:0]  up_ff;

    assign mapped   = addr <= 8'h10 && addr[1:0] == 2'h0;
    assign cfg_wr   = wr && mapped && addr < 8'h0C;
    assign settled  = quiet_ff == 6'h3F;
    assign up       = up_ff == 3'h7;
    assign rate_exp = async_ff ? {4'h0, rate_ff} * 28'hA : {4'h0, rate_ff};

    always_ff @(posedge clock) begin
        if (srst) begin
            {dce_ff, async_ff, dly0_ff, rate_ff, quiet_ff} <= {3'h1, 30'h0};
        end else begin
            quiet_ff <= cfg_wr ? 6'h0 : quiet_ff + {5'h0, !settled};
            if (wr && addr == 8'h00) {async_ff, dce_ff} <= wdata[1:0];
            if (wr && addr == 8'h04) dly0_ff <= wdata[15:0] == 16'h0;
            if (wr && addr == 8'h08) rate_ff <= wdata[23:0];
        end
    end

    always_ff @(posedge chan_clk) begin
        up_ff <= srst ? 3'h0 : up_ff + {2'h0, !up};
    end

    // ------
    // Assertions
    // ------
    a_rdata_idle: assert property (@(posedge clock) disable iff (srst)
        !rd |=> rdata == 32'h0) else $error("read data outside read cycle");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (srst)
        rd && !mapped |=> rdata == 32'h0) else $error("unmapped read not 0");
    a_rate_tenfold: assert property (
        @(posedge clock) disable iff (srst) settled |-> chan_rate == rate_exp)
        else $error("channel rate not scaled for data mode");
    a_async_sampling: assert property (
        @(posedge clock) disable iff (srst) settled && async_ff |->
        chan_timing == 3'h4) else $error("async mode not on sampling");
    a_dcd_held: assert property (
        @(posedge chan_clk) disable iff (srst) up |-> east_dcd_o)
        else $error("east carrier detect dropped");
    a_oe_split: assert property (
        @(posedge chan_clk) disable iff (srst) up |->
        west_oe_n[`SLR_W_DTR] != west_oe_n[`SLR_W_DCD])
        else $error("west lead directions inconsistent");
    a_cts_loop: assert property (
        @(posedge chan_clk) disable iff (srst)
        up && settled && !(dce_ff && dly0_ff) |->
        east_cts_o == $past(east_rts_i, 3)) else $error("east cts not looped");
    a_cts_direct: assert property (
        @(posedge chan_clk) disable iff (srst) up && settled && dce_ff &&
        dly0_ff |-> east_cts_o == $past(west_i[1], 3))
        else $error("east cts not passed from west");
    a_west_rts_held: assert property (
        @(posedge chan_clk) disable iff (srst) up && settled && dce_ff &&
        !dly0_ff |-> west_o[`SLR_W_RTS] && !west_oe_n[`SLR_W_RTS])
        else $error("west rts not held on");
    a_west_cts_loop: assert property (
        @(posedge chan_clk) disable iff (srst) up && settled && !dce_ff |->
        west_o[`SLR_W_CTS] == $past(west_i[0], 3) && !west_oe_n[`SLR_W_CTS])
        else $error("west cts not looped");

    c_direct: cover property (@(posedge chan_clk) up && settled && dce_ff
        && dly0_ff);
    c_async: cover property (@(posedge clock) settled && async_ff);
    c_err: cover property (@(posedge chan_clk) err_trig ##1 !err_trig);
endmodule

bind slr_lead_router slr_lead_router_chk u_chk (.clock(clock), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .chan_timing(chan_timing), .chan_rate(chan_rate), .chan_clk(chan_clk),
    .err_trig(err_trig), .east_rts_i(east_rts_i), .east_cts_o(east_cts_o),
    .east_dcd_o(east_dcd_o), .west_i(west_i), .west_o(west_o),
    .west_oe_n(west_oe_n));

//--- test_slr_lead_router.sv
// Directed tests of the lead router through its register port and pins
`timescale 1ns/1ps
`include "slr_consts.svh"
module test_slr_lead_router;
    logic        clock, srst, chan_clk, wr, rd, err_trig, peer_dce, peer_slow;
    logic        east_rts, east_dtr, east_sd, east_cts, east_dsr, east_dcd;
    logic        east_rd;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [2:0]  chan_timing;
    logic [27:0] chan_rate;
    logic [6:0]  west_i, west_o, west_oe_n, peer_drv;
    int          failures, compares, n;
    logic [7:0]  reg_addr [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    logic [31:0] reg_rst [5] = '{32'h100, 32'h0, 32'h0, 32'h0, 32'h0};

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        chan_clk = 1'b0;
        #3;
        forever #80 chan_clk = ~chan_clk;
    end

    slr_lead_router uut (.clock(clock), .srst(srst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .chan_timing(chan_timing), .chan_rate(chan_rate),
        .chan_clk(chan_clk), .err_trig(err_trig), .east_rts_i(east_rts),
        .east_dtr_i(east_dtr), .east_sd_i(east_sd), .east_cts_o(east_cts),
        .east_dsr_o(east_dsr), .east_dcd_o(east_dcd), .east_rd_o(east_rd),
        .west_i(west_i), .west_o(west_o), .west_oe_n(west_oe_n));
    slr_west_peer peer (.chan_clk(chan_clk), .dce(peer_dce),
        .slow(peer_slow), .drv(peer_drv), .dev_o(west_o),
        .dev_oe_n(west_oe_n), .pin(west_i));

    // ------
    // Tasks
    // ------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        {rd, addr} <= {1'b1, a};
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task cfg(input logic [7:0] a, input logic [31:0] d);
        wr_reg(a, d);
        n = 0;
        v = 32'h1;
        while (v[0] !== 1'b0 && n < 40) begin
            rd_reg(`SLR_OFF_STATUS, v);
            n++;
        end
        chk("pending", 32'h0, {31'h0, v[0]});
        repeat (6) @(posedge chan_clk);
        #1;
    endtask
    task err_evt(input logic [31:0] ctrl, input int exp);
        logic [31:0] c0, c1;
        int          cnt;
        cfg(`SLR_OFF_CTRL, ctrl);
        rd_reg(`SLR_OFF_ERRCNT, c0);
        @(posedge chan_clk);
        err_trig <= 1'b1;
        @(posedge chan_clk);
        err_trig <= 1'b0;
        cnt = 0;
        repeat (14) begin
            @(negedge chan_clk);
            if (east_rd === 1'b1) cnt++;
        end
        chk("error span", exp, cnt);
        rd_reg(`SLR_OFF_ERRCNT, c1);
        chk("error count", c0 + 32'h1, c1);
    endtask
    task end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        end_of_test;
    end

    // ------
    // Tests
    // ------
    initial begin
        {srst, wr, rd, addr, wdata, err_trig} = {3'h4, 8'h0, 32'h0, 1'b0};
        {east_rts, east_dtr, east_sd, peer_dce, peer_slow} = 5'h0;
        {peer_drv, failures, compares} = 0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        wr_reg(`SLR_OFF_ERRCNT, 32'hFFFF);
        wr_reg(8'h14, 32'hFFFFFFFF);
        for (int i = 0; i < 5; i++) begin
            rd_reg(reg_addr[i], v);
            chk("reset register", reg_rst[i], v);
        end
        repeat (8) @(posedge chan_clk);
        #1;
        chk("west oe terminal", 32'h31, west_oe_n);
        $display("test reset done");
        for (int b = 0; b < 2; b++) begin
            @(posedge clock);
            {east_rts, east_sd} <= {2{b[0]}};
            peer_drv <= b[0] ? 7'h00 : 7'h31;
            repeat (6) @(posedge chan_clk);
            #1;
            chk("east cts", b, east_cts);
            chk("east dsr dcd", 2'h3, {east_dsr, east_dcd});
            chk("west cts", !b, west_o[1]);
            chk("west dsr dcd", 2'h3, west_o[3:2]);
            chk("west rd", b, west_o[6]);
            chk("east rd", !b, east_rd);
        end
        $display("test terminal route done");
        cfg(`SLR_OFF_DELAY, 32'h5);
        peer_dce <= 1'b1;
        cfg(`SLR_OFF_CTRL, 32'h101);
        chk("west oe dce", 32'h4E, west_oe_n);
        for (int b = 0; b < 2; b++) begin
            @(posedge clock);
            {east_rts, east_sd} <= {2{b[0]}};
            peer_drv <= b[0] ? 7'h00 : 7'h42;
            repeat (6) @(posedge chan_clk);
            #1;
            chk("east cts", b, east_cts);
            chk("east dsr dcd", 2'h3, {east_dsr, east_dcd});
            chk("west rts dtr", 2'h3, {west_o[0], west_o[4]});
            chk("west sd", b, west_o[5]);
            chk("east rd", !b, east_rd);
        end
        $display("test delayed route done");
        peer_slow <= 1'b1;
        cfg(`SLR_OFF_DELAY, 32'h0);
        for (int b = 0; b < 2; b++) begin
            @(posedge clock);
            {east_rts, east_dtr} <= {b[0], !b[0]};
            peer_drv <= b[0] ? 7'h04 : 7'h02;
            repeat (6) @(posedge chan_clk);
            #1;
            chk("east cts dsr", {!b[0], b[0]}, {east_cts, east_dsr});
            chk("east dcd", 1, east_dcd);
            chk("west rts dtr", {b[0], !b[0]}, {west_o[0], west_o[4]});
        end
        $display("test direct route done");
        {peer_dce, peer_slow, peer_drv} <= 9'h0;
        cfg(`SLR_OFF_RATE, 32'h2580);
        for (int t = 0; t < 4; t++) begin
            cfg(`SLR_OFF_CTRL, t << 4);
            chk("timing sync", t, chan_timing);
            chk("rate sync", 32'h2580, chan_rate);
        end
        cfg(`SLR_OFF_CTRL, 32'h112);
        chk("timing async", 32'h4, chan_timing);
        chk("rate async", 32'h17700, chan_rate);
        rd_reg(`SLR_OFF_STATUS, v);
        chk("status", 32'h014C0042, v);
        $display("test data mode done");
        err_evt(32'h300, 3);
        err_evt(32'h000, 1);
        err_evt(32'h102, 1);
        err_evt(32'h502, 1);
        $display("test error events done");
        end_of_test;
    end
endmodule
